// File: hw/wcd_decode.sv
// Combinational decoder from configuration word to watchdog settings.
`default_nettype none
module wcd_decode
(
  input wire logic [31:0] cfg_word,
  output var wcd_pkg::wcd_set_t settings
);
  import wcd_pkg::*;

  // Map the two-bit window code to eighths of the period.
  function automatic logic [3:0] win_map(input logic [1:0] code);
    case (code)
      2'b11: win_map = WCD_WIN_25;
      2'b10: win_map = WCD_WIN_375;
      2'b01: win_map = WCD_WIN_50;
      default: win_map = WCD_WIN_75;
    endcase
  endfunction : win_map

  logic [4:0] ps_raw;

  // Codes above the top entry saturate at the largest ratio.
  always_comb
  begin
    ps_raw = cfg_word[WCD_PS_LSB +: 5];
    settings.win_eighths = win_map(cfg_word[WCD_WINSZ_LSB +: 2]);
    settings.forced_on = cfg_word[WCD_FORCED_BIT];
    settings.window_off = cfg_word[WCD_WINOFF_BIT];
    settings.ps_exp = (ps_raw > WCD_PS_MAX) ? WCD_PS_MAX : ps_raw;
    settings.rsv_ok = ((cfg_word & WCD_RSV_MASK) == WCD_RSV_MASK);
  end
endmodule : wcd_decode
`default_nettype wire

// File: hw/wcd_pkg.sv
// Package of constants and types for the watchdog configuration word decoder.
`default_nettype none
package wcd_pkg;
  // Field positions inside the configuration word.
  localparam int WCD_WINSZ_LSB = 24;
  localparam int WCD_FORCED_BIT = 23;
  localparam int WCD_WINOFF_BIT = 22;
  localparam int WCD_PS_LSB = 16;
  localparam logic [31:0] WCD_RSV_MASK = 32'hFC20_0000;
  localparam logic [4:0] WCD_PS_MAX = 5'h14;
  // Register byte addresses.
  localparam logic [3:0] WCD_OFF_CFG = 4'h0;
  localparam logic [3:0] WCD_OFF_CTRL = 4'h4;
  localparam logic [3:0] WCD_OFF_STAT = 4'h8;
  // Reset values and response codes.
  localparam logic WCD_CTRL_RST = 1'b0;
  localparam logic [1:0] WCD_RESP_OKAY = 2'b00;
  localparam logic [1:0] WCD_RESP_SLVERR = 2'b10;
  // Window size expressed in eighths of the timeout period.
  localparam logic [3:0] WCD_WIN_75 = 4'h6;
  localparam logic [3:0] WCD_WIN_50 = 4'h4;
  localparam logic [3:0] WCD_WIN_375 = 4'h3;
  localparam logic [3:0] WCD_WIN_25 = 4'h2;

  // Decoded watchdog settings.
  typedef struct packed {
    logic [3:0] win_eighths;
    logic forced_on;
    logic window_off;
    logic [4:0] ps_exp;
    logic rsv_ok;
  } wcd_set_t;
endpackage : wcd_pkg
`default_nettype wire

// File: hw/wcd_top.sv
// Watchdog configuration word decoder with AXI4-Lite register access.
// Functional notes
// - Window code 11,10,01,00 gives 25, 37.5, 50, 75 percent open window.
// - Forced-on bit set runs watchdog from reset; software cannot turn it off.
// - Forced-on bit clear leaves watchdog off, but software may switch it on.
// - Window-off bit one selects non-window mode, zero selects window mode.
// - Postscale field selects divide ratio two to the field value, up to 2^20.
// - Postscale codes above the largest listed code act as the largest code.
//
// Implementation choices: the AXI4-Lite register port and the register addresses.
`default_nettype none
module wcd_top
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [31:0] cfg_word,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic wd_run,
  output logic [3:0] wd_window_size,
  output logic wd_window_off,
  output logic [20:0] wd_postscale_ratio,
  output logic [4:0] wd_postscale_select,
  output logic wd_cfg_reserved_ok
);
  import wcd_pkg::*;

  wcd_set_t dec_set;
  wcd_set_t set_ff;
  logic captured_ff;
  logic sw_on_ff;
  logic [31:0] word_ff;
  logic aw_hold_ff;
  logic w_hold_ff;
  logic [3:0] aw_addr_ff;
  logic [31:0] w_data_ff;
  logic [3:0] w_strb_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;
  logic wr_fire;

  wcd_decode u_decode
  (
    .cfg_word(cfg_word),
    .settings(dec_set)
  );

  // The word is sampled on the first edge after reset release, so the asynchronous
  // reset only loads constants and the strap value is caught by a clocked step.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      captured_ff <= 1'b0;
      set_ff <= '0;
      word_ff <= '0;
    end
    else if (!captured_ff)
    begin
      captured_ff <= 1'b1;
      set_ff <= dec_set;
      word_ff <= cfg_word;
    end
  end

  // Write channel handshakes: address and data are taken in either order.
  assign s_axi_awready = !aw_hold_ff && !bvalid_ff;
  assign s_axi_wready = !w_hold_ff && !bvalid_ff;
  assign wr_fire = aw_hold_ff && w_hold_ff && !bvalid_ff;

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      aw_hold_ff <= 1'b0;
      w_hold_ff <= 1'b0;
      aw_addr_ff <= '0;
      w_data_ff <= '0;
      w_strb_ff <= '0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_hold_ff <= 1'b1;
        aw_addr_ff <= s_axi_awaddr;
      end
      else if (wr_fire)
        aw_hold_ff <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_hold_ff <= 1'b1;
        w_data_ff <= s_axi_wdata;
        w_strb_ff <= s_axi_wstrb;
      end
      else if (wr_fire)
        w_hold_ff <= 1'b0;
    end
  end

  // Software run request; a clear is stored, but wd_run stays on while the word forces the watchdog on.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      sw_on_ff <= WCD_CTRL_RST;
    else if (wr_fire && aw_addr_ff == WCD_OFF_CTRL && w_strb_ff[0])
      sw_on_ff <= w_data_ff[0];
  end

  // Write response; only the control register takes writes.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      bvalid_ff <= 1'b0;
      bresp_ff <= WCD_RESP_OKAY;
    end
    else if (wr_fire)
    begin
      bvalid_ff <= 1'b1;
      bresp_ff <= (aw_addr_ff == WCD_OFF_CTRL) ? WCD_RESP_OKAY : WCD_RESP_SLVERR;
    end
    else if (s_axi_bready)
      bvalid_ff <= 1'b0;
  end

  // Read channel; the configuration word itself is read-only.
  assign s_axi_arready = !rvalid_ff;

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      rvalid_ff <= 1'b0;
      rdata_ff <= '0;
      rresp_ff <= WCD_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_ff <= 1'b1;
      rresp_ff <= WCD_RESP_OKAY;
      case (s_axi_araddr)
        WCD_OFF_CFG: rdata_ff <= word_ff;
        WCD_OFF_CTRL: rdata_ff <= {31'h0000_0000, sw_on_ff};
        WCD_OFF_STAT: rdata_ff <= {18'h0_0000, set_ff.rsv_ok, set_ff.ps_exp, set_ff.win_eighths,
                                   set_ff.window_off, set_ff.forced_on, wd_run, captured_ff};
        default:
        begin
          rdata_ff <= '0;
          rresp_ff <= WCD_RESP_SLVERR;
        end
      endcase
    end
    else if (s_axi_rready)
      rvalid_ff <= 1'b0;
  end

  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

  // Settings to the watchdog counter; nothing runs before the word is captured.
  assign wd_run = captured_ff && (set_ff.forced_on || sw_on_ff);
  assign wd_window_size = set_ff.win_eighths;
  assign wd_window_off = set_ff.window_off;
  assign wd_postscale_select = set_ff.ps_exp;
  assign wd_postscale_ratio = 21'h00_0001 << set_ff.ps_exp;
  assign wd_cfg_reserved_ok = set_ff.rsv_ok;

  // Watchdog runs whenever the word forces it on, whatever software writes.
  property p_forced_run;
    @(posedge core_clk) disable iff (rst) (captured_ff && set_ff.forced_on) |-> wd_run;
  endproperty
  a_forced_run: assert property (p_forced_run) else $error("forced watchdog not running");

  // Without the force bit, the watchdog is off until software switches it on.
  property p_off_default;
    @(posedge core_clk) disable iff (rst) (!set_ff.forced_on && !sw_on_ff) |-> !wd_run;
  endproperty
  a_off_default: assert property (p_off_default) else $error("watchdog running without enable");

  // A software enable write takes effect on the following cycle.
  property p_sw_on;
    @(posedge core_clk) disable iff (rst)
      (captured_ff && wr_fire && aw_addr_ff == WCD_OFF_CTRL && w_strb_ff[0] && w_data_ff[0]) |=> wd_run;
  endproperty
  a_sw_on: assert property (p_sw_on) else $error("software enable ignored");

  // Window size mapping.
  property p_window;
    @(posedge core_clk) disable iff (rst)
      captured_ff |-> (wd_window_size == ((word_ff[25:24] == 2'b11) ? WCD_WIN_25 :
                       (word_ff[25:24] == 2'b10) ? WCD_WIN_375 :
                       (word_ff[25:24] == 2'b01) ? WCD_WIN_50 : WCD_WIN_75));
  endproperty
  a_window: assert property (p_window) else $error("window size decode wrong");

  // Window-off follows bit 22 of the captured word.
  property p_winoff;
    @(posedge core_clk) disable iff (rst) captured_ff |-> (wd_window_off == word_ff[22]);
  endproperty
  a_winoff: assert property (p_winoff) else $error("window mode decode wrong");

  // Listed postscale codes give two to the code.
  property p_ps_listed;
    @(posedge core_clk) disable iff (rst)
      (captured_ff && word_ff[20:16] <= 5'h14) |-> (wd_postscale_ratio == (21'h00_0001 << word_ff[20:16]));
  endproperty
  a_ps_listed: assert property (p_ps_listed) else $error("postscale ratio wrong");

  // Unlisted postscale codes saturate.
  property p_ps_sat;
    @(posedge core_clk) disable iff (rst)
      (captured_ff && word_ff[20:16] > 5'h14) |-> (wd_postscale_ratio == 21'h10_0000);
  endproperty
  a_ps_sat: assert property (p_ps_sat) else $error("postscale not saturated");

  // Captured settings never change until reset.
  property p_hold;
    @(posedge core_clk) disable iff (rst) captured_ff |=> ($stable(set_ff) && captured_ff);
  endproperty
  a_hold: assert property (p_hold) else $error("settings changed after capture");

  // Reserved-bit check flag matches the captured word.
  property p_rsv;
    @(posedge core_clk) disable iff (rst)
      captured_ff |-> (wd_cfg_reserved_ok == (word_ff[31:26] == 6'h3F && word_ff[21]));
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bit check wrong");

  // A control-register write is under way once both channels are held.
  sequence s_ctrl_wr;
    wr_fire && (aw_addr_ff == WCD_OFF_CTRL) && w_strb_ff[0];
  endsequence

  // The write answer stands with an okay code.
  sequence s_ok_resp;
    s_axi_bvalid && (s_axi_bresp == WCD_RESP_OKAY);
  endsequence

  // Every control write is answered one cycle later with okay.
  property p_ctrl_resp;
    @(posedge core_clk) disable iff (rst) s_ctrl_wr |=> s_ok_resp;
  endproperty
  a_ctrl_resp: assert property (p_ctrl_resp) else $error("control write not answered with okay");

  // A software clear is answered but must not stop a forced watchdog.
  property p_forced_clear;
    @(posedge core_clk) disable iff (rst)
      (s_ctrl_wr ##0 (captured_ff && set_ff.forced_on && !w_data_ff[0])) |=> (s_ok_resp ##0 wd_run);
  endproperty
  a_forced_clear: assert property (p_forced_clear) else $error("software cleared a forced watchdog");

  // Writes to any other place change nothing and are refused.
  property p_wr_refused;
    @(posedge core_clk) disable iff (rst)
      (wr_fire && aw_addr_ff != WCD_OFF_CTRL) |=>
      ($stable(sw_on_ff) && s_axi_bvalid && s_axi_bresp == WCD_RESP_SLVERR);
  endproperty
  a_wr_refused: assert property (p_wr_refused) else $error("write to read-only place accepted");

  // Software sees the word exactly as it was captured at reset.
  sequence s_cfg_read;
    s_axi_arvalid && s_axi_arready && (s_axi_araddr == WCD_OFF_CFG);
  endsequence
  property p_cfg_read;
    @(posedge core_clk) disable iff (rst) s_cfg_read |=> (s_axi_rvalid && s_axi_rdata == word_ff);
  endproperty
  a_cfg_read: assert property (p_cfg_read) else $error("configuration word read back wrong");

  // Unmapped reads return zero with an error code.
  property p_rd_unmapped;
    @(posedge core_clk) disable iff (rst)
      (s_axi_arvalid && s_axi_arready && s_axi_araddr != WCD_OFF_CFG && s_axi_araddr != WCD_OFF_CTRL &&
       s_axi_araddr != WCD_OFF_STAT) |=> (s_axi_rvalid && s_axi_rresp == WCD_RESP_SLVERR && s_axi_rdata == '0);
  endproperty
  a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not refused");

  // The saturated exponent never exceeds the largest listed code.
  property p_ps_bound;
    @(posedge core_clk) disable iff (rst) captured_ff |-> (wd_postscale_select <= WCD_PS_MAX);
  endproperty
  a_ps_bound: assert property (p_ps_bound) else $error("postscale exponent above the largest code");

  // The capture edge loads what the decoder showed at that same edge.
  sequence s_capture;
    !captured_ff ##1 captured_ff;
  endsequence
  property p_capture;
    @(posedge core_clk) disable iff (rst) s_capture |-> (set_ff == $past(dec_set) && word_ff == $past(cfg_word));
  endproperty
  a_capture: assert property (p_capture) else $error("settings not loaded from the word at reset");
endmodule : wcd_top
`default_nettype wire

// File: testbench/tb_wcd_top.sv
// Self-checking testbench for the watchdog configuration word decoder.
`default_nettype none
module tb_wcd_top;
  timeunit 1ns;
  timeprecision 100ps;
  import wcd_pkg::*;
  logic core_clk, rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic [31:0] cfg_word, s_axi_wdata, s_axi_rdata, wd, rd;
  logic [3:0] s_axi_awaddr, s_axi_wstrb, s_axi_araddr, wd_window_size;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic wd_run, wd_window_off, wd_cfg_reserved_ok;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [20:0] wd_postscale_ratio;
  logic [4:0] wd_postscale_select, e;
  int miscompares, cmp_count, seed, i;
  wcd_top u_dut (.core_clk(core_clk), .rst(rst), .cfg_word(cfg_word), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .wd_run(wd_run), .wd_window_size(wd_window_size),
    .wd_window_off(wd_window_off), .wd_postscale_ratio(wd_postscale_ratio),
    .wd_postscale_select(wd_postscale_select), .wd_cfg_reserved_ok(wd_cfg_reserved_ok));
  // The clock runs at 40 MHz.
  initial
  begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  // Open window in eighths expected for each window code.
  function automatic logic [3:0] exp_win(input logic [1:0] c);
    return (c == 2'b11) ? WCD_WIN_25 : (c == 2'b10) ? WCD_WIN_375 : (c == 2'b01) ? WCD_WIN_50 : WCD_WIN_75;
  endfunction : exp_win
  // Codes past the largest listed one saturate at the largest.
  function automatic logic [4:0] exp_ps(input logic [4:0] c);
    return (c > 5'h14) ? 5'h14 : c;
  endfunction : exp_ps
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : conclude
  // Write; ready is sampled mid-cycle so each channel is released at the edge that took it.
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw, w, b;
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(negedge core_clk);
      aw = s_axi_awvalid && s_axi_awready;
      w = s_axi_wvalid && s_axi_wready;
      b = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge core_clk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
      if (b) s_axi_bready <= 1'b0;
    end while (!b);
    @(negedge core_clk);
  endtask : axi_wr
  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar, b;
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(negedge core_clk);
      ar = s_axi_arvalid && s_axi_arready;
      b = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge core_clk);
      if (ar) s_axi_arvalid <= 1'b0;
      if (b) s_axi_rready <= 1'b0;
    end while (!b);
    @(negedge core_clk);
  endtask : axi_rd
  // Reset with a new word present; the word must be stable around the release.
  task automatic do_reset(input logic [31:0] w, input int cyc);
    @(posedge core_clk);
    cfg_word <= w;
    rst <= 1'b1;
    repeat (cyc) @(posedge core_clk);
    rst <= 1'b0;
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
  endtask : do_reset
  // Hang guard, sized well beyond the expected run.
  initial
  begin
    #(25 * 20000);
    miscompares++;
    conclude();
  end
  // Main sequence: random words with every postscale and window code forced in turn.
  initial
  begin
    rst = 1'b1;
    {cfg_word, s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hf;
    seed = 32'h12ff;
    miscompares = 0;
    cmp_count = 0;
    do_reset(32'hFFFF_FFFF, 12);
    for (i = 0; i < 32; i++)
    begin
      wd = $random(seed);
      wd[20:16] = i[4:0];
      wd[25:24] = i[1:0];
      if (i[0]) wd = wd | WCD_RSV_MASK;
      do_reset(wd, 2);
      e = exp_ps(wd[20:16]);
      chk(wd_window_size, exp_win(wd[25:24]));
      chk(wd_window_off, wd[22]);
      chk(wd_postscale_select, e);
      chk(wd_postscale_ratio, 21'h1 << e);
      chk(wd_cfg_reserved_ok, (wd & WCD_RSV_MASK) == WCD_RSV_MASK);
      chk(wd_run, wd[23]);
      axi_rd(WCD_OFF_CFG, rd, rsp);
      chk(rd, wd);
      chk(rsp, WCD_RESP_OKAY);
      axi_rd(WCD_OFF_CTRL, rd, rsp);
      chk(rd, {31'h0000_0000, WCD_CTRL_RST});
      axi_rd(WCD_OFF_STAT, rd, rsp);
      chk(rd, {18'h0_0000, (wd & WCD_RSV_MASK) == WCD_RSV_MASK, e, exp_win(wd[25:24]), wd[22], wd[23], wd[23], 1'b1});
      axi_wr(WCD_OFF_CTRL, 32'h0000_0001, rsp);
      chk(rsp, WCD_RESP_OKAY);
      chk(wd_run, 1'b1);
      axi_wr(WCD_OFF_CTRL, 32'h0000_0000, rsp);
      chk(rsp, WCD_RESP_OKAY);
      chk(wd_run, wd[23]);
      @(posedge core_clk);
      cfg_word <= ~wd;
      repeat (3) @(negedge core_clk);
      chk(wd_postscale_select, e);
      chk(wd_window_off, wd[22]);
      $display("test iteration %0d done", i);
    end
    // Refused accesses: read-only word and status register, an unmapped place.
    axi_wr(WCD_OFF_CFG, 32'h0000_0000, rsp);
    chk(rsp, WCD_RESP_SLVERR);
    axi_wr(WCD_OFF_STAT, 32'h0000_0001, rsp);
    chk(rsp, WCD_RESP_SLVERR);
    axi_rd(WCD_OFF_CTRL, rd, rsp);
    chk(rd[0], 1'b0);
    axi_rd(4'hC, rd, rsp);
    chk({rsp, rd}, {WCD_RESP_SLVERR, 32'h0000_0000});
    axi_rd(WCD_OFF_CFG, rd, rsp);
    chk(rd, wd);
    $display("test refused accesses done");
    conclude();
  end
endmodule : tb_wcd_top
`default_nettype wire
